// [pll_ctrl_regs.vh]
// Purpose: Register map, field positions and reset values of the loop
//          clock controller.
// Assumes: Byte addresses relative to the controller base.
// Notes:   Definitions only.
`ifndef PLL_CTRL_REGS_VH
`define PLL_CTRL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_W 10
`define OFF_LOOP_CONTROL 10'h100
`define OFF_LOOP_MULTIPLIER 10'h110
`define OFF_DIVIDER_ONE 10'h118
`define OFF_DIVIDER_TWO 10'h11c
`define OFF_GO_COMMAND 10'h138
`define OFF_DIVIDER_STATUS 10'h13c

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTL_REFERENCE_SELECT 8
`define CTL_RSVD_HI 7
`define CTL_RSVD_LO 6
`define CTL_ENABLE_SOURCE_GATE 5
`define CTL_LOOP_DISABLE 4
`define CTL_LOOP_RESET_RELEASE 3
`define CTL_LOOP_POWER_DOWN 1
`define CTL_BYPASS_OFF_SELECT 0
`define CTL_RSVD_VALUE 2'h3

// ----------------------------------------------------------------
// Multiplier and divider fields
// ----------------------------------------------------------------
`define MULT_HI 4
`define MULT_LO 0
`define MULT_W 5
`define MULT_RESET 5'h10
`define DIV_ENABLE 15
`define DIV_RATIO_HI 3
`define DIV_RATIO_LO 0
`define DIV_RATIO_W 4
`define CMD_GO 0
`define STAT_RATIO_ONE_LO 0
`define STAT_RATIO_TWO_LO 4
`define STAT_PLL_MODE 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTL_REFERENCE_SELECT_RST 1'b0
`define CTL_ENABLE_SOURCE_GATE_RST 1'b1
`define CTL_LOOP_DISABLE_RST 1'b1
`define CTL_LOOP_RESET_RELEASE_RST 1'b0
`define CTL_LOOP_POWER_DOWN_RST 1'b1
`define CTL_BYPASS_OFF_SELECT_RST 1'b0
`define DIV_ONE_ENABLE_RST 1'b0
`define DIV_TWO_ENABLE_RST 1'b1
`define DIV_ONE_RATIO_FIRST 4'h0
`define DIV_ONE_RATIO_SECOND 4'h1
`define DIV_TWO_RATIO_FIRST 4'h1
`define DIV_TWO_RATIO_SECOND 4'h9

`endif

// [pin_edge_sync.v]
// Purpose: Bring an outside clock pin into the bus clock domain and
//          mark its rising edges.
// Assumes: Pin toggles slower than half the bus clock.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module pin_edge_sync (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Pin and edge
  input wire i_pin,
  output reg o_rise
);

  reg meta;
  reg stable;
  reg last;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      meta <= i_pin;
      stable <= meta;
      last <= stable;
      o_rise <= stable & ~last;
    end
  end

endmodule

// [ratio_divider.v]
// Purpose: Divide a stream of source edges by ratio plus one.
// Assumes: Source ticks are one cycle wide.
// Notes:   A new ratio is compared with the count from the next source tick.
`timescale 1ns/1ps
module ratio_divider #(
  parameter RATIO_W = 4
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Control
  input wire i_enable,
  input wire [RATIO_W-1:0] i_ratio,
  // Source and output ticks
  input wire i_src_tick,
  output reg o_tick
);

  reg [RATIO_W-1:0] count;

  always @(posedge i_mclk) begin
    if (!i_rst_n || !i_enable) begin
      count <= {RATIO_W{1'b0}};
      o_tick <= 1'b0;
    end else if (i_src_tick) begin
      if (count >= i_ratio) begin
        count <= {RATIO_W{1'b0}};
        o_tick <= 1'b1;
      end else begin
        count <= count + {{(RATIO_W-1){1'b0}}, 1'b1};
        o_tick <= 1'b0;
      end
    end else begin
      o_tick <= 1'b0;
    end
  end

endmodule

// [loop_clock_control.v]
// Purpose: Control, multiplier and two system clock dividers of a
//          loop clock controller, reached over a simple register port.
// Assumes: Reference and loop clocks arrive as pins much slower than
//          the bus clock; system clocks leave as one-cycle ticks.
// Notes:   SECOND_CONTROLLER picks the instance flavour.
`timescale 1ns/1ps
`include "pll_ctrl_regs.vh"

// Behaviour
// - Mode select ignored while source gate set
// - Control bit 4 drives loop disable
// - Control bit 3 low holds loop reset
// - Bit 0 picks reference or loop clock
// - Multiplication factor is field plus one
// - Divider divides by ratio plus one
// - Divider one makes system clock one
// - Divider two makes system clock two
// - First controller ratios ignore writes
// - Divider one ratio reset per instance
// - Divider two ratio reset per instance
module loop_clock_control #(
  parameter SECOND_CONTROLLER = 0
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Register port
  input wire [`ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Clock pins
  input wire i_oscillator_input,
  input wire i_external_square_clock,
  input wire i_loop_clock,
  // Analog loop controls
  output reg o_loop_disable,
  output reg o_loop_reset_n,
  output reg o_loop_power_down,
  output reg [`MULT_W:0] o_loop_multiply_factor,
  output reg o_reference_select,
  output reg o_bypass_off,
  // System clocks
  output wire o_system_clock_one,
  output wire o_system_clock_two
);

  // ----------------------------------------------------------------
  // Per-instance reset values
  // ----------------------------------------------------------------
  localparam [`DIV_RATIO_W-1:0] RATIO_ONE_RST = SECOND_CONTROLLER ?
    `DIV_ONE_RATIO_SECOND : `DIV_ONE_RATIO_FIRST;
  localparam [`DIV_RATIO_W-1:0] RATIO_TWO_RST = SECOND_CONTROLLER ?
    `DIV_TWO_RATIO_SECOND : `DIV_TWO_RATIO_FIRST;
  localparam RATIO_WRITABLE = (SECOND_CONTROLLER != 0);
  localparam NUM_PINS = 3;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg reference_select;
  reg enable_source_gate;
  reg loop_disable;
  reg loop_reset_release;
  reg loop_power_down;
  reg bypass_off_select;
  reg [`MULT_W-1:0] loop_multiplier;
  reg divider_one_enable;
  reg divider_two_enable;
  reg [`DIV_RATIO_W-1:0] pending_ratio_one;
  reg [`DIV_RATIO_W-1:0] pending_ratio_two;
  reg [`DIV_RATIO_W-1:0] active_ratio_one;
  reg [`DIV_RATIO_W-1:0] active_ratio_two;
  reg [31:0] next_rdata;

  wire [NUM_PINS-1:0] pin_in;
  wire [NUM_PINS-1:0] pin_rise;
  wire ref_tick;
  wire src_tick;
  wire wr_control;
  wire wr_mult;
  wire wr_div_one;
  wire wr_div_two;
  wire wr_go;

  assign wr_control = i_wr && (i_addr == `OFF_LOOP_CONTROL);
  assign wr_mult = i_wr && (i_addr == `OFF_LOOP_MULTIPLIER);
  assign wr_div_one = i_wr && (i_addr == `OFF_DIVIDER_ONE);
  assign wr_div_two = i_wr && (i_addr == `OFF_DIVIDER_TWO);
  assign wr_go = i_wr && (i_addr == `OFF_GO_COMMAND) &&
                 i_wdata[`CMD_GO];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      reference_select <= `CTL_REFERENCE_SELECT_RST;
      enable_source_gate <= `CTL_ENABLE_SOURCE_GATE_RST;
      loop_disable <= `CTL_LOOP_DISABLE_RST;
      loop_reset_release <= `CTL_LOOP_RESET_RELEASE_RST;
      loop_power_down <= `CTL_LOOP_POWER_DOWN_RST;
      bypass_off_select <= `CTL_BYPASS_OFF_SELECT_RST;
      loop_multiplier <= `MULT_RESET;
    end else begin
      if (wr_control) begin
        reference_select <= i_wdata[`CTL_REFERENCE_SELECT];
        enable_source_gate <= i_wdata[`CTL_ENABLE_SOURCE_GATE];
        loop_disable <= i_wdata[`CTL_LOOP_DISABLE];
        loop_reset_release <= i_wdata[`CTL_LOOP_RESET_RELEASE];
        loop_power_down <= i_wdata[`CTL_LOOP_POWER_DOWN];
        bypass_off_select <= i_wdata[`CTL_BYPASS_OFF_SELECT];
      end
      if (wr_mult) begin
        loop_multiplier <= i_wdata[`MULT_HI:`MULT_LO];
      end
    end
  end

  // Enables act at once; ratios wait for the go command so both
  // dividers switch together.
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      divider_one_enable <= `DIV_ONE_ENABLE_RST;
      divider_two_enable <= `DIV_TWO_ENABLE_RST;
      pending_ratio_one <= RATIO_ONE_RST;
      pending_ratio_two <= RATIO_TWO_RST;
      active_ratio_one <= RATIO_ONE_RST;
      active_ratio_two <= RATIO_TWO_RST;
    end else begin
      if (wr_div_one) begin
        divider_one_enable <= i_wdata[`DIV_ENABLE];
        if (RATIO_WRITABLE) begin
          pending_ratio_one <= i_wdata[`DIV_RATIO_HI:`DIV_RATIO_LO];
        end
      end
      if (wr_div_two) begin
        divider_two_enable <= i_wdata[`DIV_ENABLE];
        if (RATIO_WRITABLE) begin
          pending_ratio_two <= i_wdata[`DIV_RATIO_HI:`DIV_RATIO_LO];
        end
      end
      if (wr_go) begin
        active_ratio_one <= pending_ratio_one;
        active_ratio_two <= pending_ratio_two;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      `OFF_LOOP_CONTROL: begin
        next_rdata[`CTL_REFERENCE_SELECT] = reference_select;
        next_rdata[`CTL_RSVD_HI:`CTL_RSVD_LO] = `CTL_RSVD_VALUE;
        next_rdata[`CTL_ENABLE_SOURCE_GATE] = enable_source_gate;
        next_rdata[`CTL_LOOP_DISABLE] = loop_disable;
        next_rdata[`CTL_LOOP_RESET_RELEASE] = loop_reset_release;
        next_rdata[`CTL_LOOP_POWER_DOWN] = loop_power_down;
        next_rdata[`CTL_BYPASS_OFF_SELECT] = bypass_off_select;
      end
      `OFF_LOOP_MULTIPLIER: begin
        next_rdata[`MULT_HI:`MULT_LO] = loop_multiplier;
      end
      `OFF_DIVIDER_ONE: begin
        next_rdata[`DIV_ENABLE] = divider_one_enable;
        next_rdata[`DIV_RATIO_HI:`DIV_RATIO_LO] = pending_ratio_one;
      end
      `OFF_DIVIDER_TWO: begin
        next_rdata[`DIV_ENABLE] = divider_two_enable;
        next_rdata[`DIV_RATIO_HI:`DIV_RATIO_LO] = pending_ratio_two;
      end
      `OFF_DIVIDER_STATUS: begin
        next_rdata[`STAT_RATIO_ONE_LO+`DIV_RATIO_W-1:`STAT_RATIO_ONE_LO] =
          active_ratio_one;
        next_rdata[`STAT_RATIO_TWO_LO+`DIV_RATIO_W-1:`STAT_RATIO_TWO_LO] =
          active_ratio_two;
        next_rdata[`STAT_PLL_MODE] = o_bypass_off;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Data only in the cycle after the read strobe
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Analog loop controls
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_loop_disable <= `CTL_LOOP_DISABLE_RST;
      o_loop_reset_n <= `CTL_LOOP_RESET_RELEASE_RST;
      o_loop_power_down <= `CTL_LOOP_POWER_DOWN_RST;
      o_loop_multiply_factor <= {1'b0, `MULT_RESET} +
                                {{`MULT_W{1'b0}}, 1'b1};
      o_reference_select <= `CTL_REFERENCE_SELECT_RST;
      o_bypass_off <= 1'b0;
    end else begin
      o_loop_disable <= loop_disable;
      o_loop_reset_n <= loop_reset_release;
      o_loop_power_down <= loop_power_down;
      o_loop_multiply_factor <= {1'b0, loop_multiplier} +
                                {{`MULT_W{1'b0}}, 1'b1};
      o_reference_select <= reference_select;
      // Mode bit is dead until the source gate is cleared
      o_bypass_off <= bypass_off_select & ~enable_source_gate;
    end
  end

  // ----------------------------------------------------------------
  // Clock pins and source selection
  // ----------------------------------------------------------------
  assign pin_in = {i_loop_clock, i_external_square_clock,
                   i_oscillator_input};

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
      pin_edge_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pin(pin_in[g]),
        .o_rise(pin_rise[g])
      );
    end
  endgenerate

  // Select follows registered controls, so a switch may drop or
  // double one source edge; acceptable for a tick-level model.
  assign ref_tick = o_reference_select ? pin_rise[1] : pin_rise[0];
  assign src_tick = o_bypass_off ? pin_rise[2] : ref_tick;

  // ----------------------------------------------------------------
  // System clock dividers
  // ----------------------------------------------------------------
  ratio_divider #(
    .RATIO_W(`DIV_RATIO_W)
  ) u_div_one (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_enable(divider_one_enable),
    .i_ratio(active_ratio_one),
    .i_src_tick(src_tick),
    .o_tick(o_system_clock_one)
  );

  ratio_divider #(
    .RATIO_W(`DIV_RATIO_W)
  ) u_div_two (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_enable(divider_two_enable),
    .i_ratio(active_ratio_two),
    .i_src_tick(src_tick),
    .o_tick(o_system_clock_two)
  );

endmodule

// [clock_pin_source.sv]
// Purpose: Free-running oscillator, external and loop clock pins.
// Assumes: Pins toggle on bus clock edges, slow enough for the sync.
// Notes:   Half periods in bus cycles; distinct so sources differ.
`timescale 1ns/1ps
module clock_pin_source #(
  parameter OSC_HALF = 3,
  parameter EXT_HALF = 4,
  parameter LOOP_HALF = 5
) (
  // Clock
  input wire i_mclk,
  // Pins
  output logic o_osc,
  output logic o_ext,
  output logic o_loop
);
  int c = 0;
  initial begin
    {o_osc, o_ext, o_loop} = 3'h0;
  end
  always @(posedge i_mclk) begin
    c <= c + 1;
    if (c % OSC_HALF == 0)
      o_osc <= ~o_osc;
    if (c % EXT_HALF == 0)
      o_ext <= ~o_ext;
    if (c % LOOP_HALF == 0)
      o_loop <= ~o_loop;
  end
endmodule

// [pll_control_and_divider_regs_chk.sv]
// Purpose: Port-level checks of the loop clock controller.
// Assumes: Pins stay high and low at least two bus cycles each.
// Notes:   Control outputs land two edges after the write edge.
`timescale 1ns/1ps
`include "pll_ctrl_regs.vh"
module pll_control_and_divider_regs_chk (
  // Clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // Register port
  input wire [`ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  // Loop controls and ticks
  input wire o_loop_disable,
  input wire o_loop_reset_n,
  input wire o_loop_power_down,
  input wire [`MULT_W:0] o_loop_multiply_factor,
  input wire o_reference_select,
  input wire o_bypass_off,
  input wire o_system_clock_one,
  input wire o_system_clock_two
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  wire ctl_wr = i_wr && i_addr == `OFF_LOOP_CONTROL;
  wire mul_wr = i_wr && i_addr == `OFF_LOOP_MULTIPLIER;
  // A source switch may bunch two ticks; spacing holds on a steady source
  logic [2:0] sel_age = 3'h0;
  logic [1:0] sel_last = 2'h0;
  always @(posedge i_mclk) begin
    sel_last <= {o_reference_select, o_bypass_off};
    if (!i_rst_n || sel_last != {o_reference_select, o_bypass_off})
      sel_age <= 3'h0;
    else if (sel_age != 3'h7)
      sel_age <= sel_age + 3'h1;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_disable;
    ctl_wr |-> ##2 o_loop_disable == $past(i_wdata[4], 2);
  endproperty
  a_disable: assert property (p_disable)
    else $error("loop disable wrong after control write");
  property p_reset;
    ctl_wr |-> ##2 o_loop_reset_n == $past(i_wdata[3], 2);
  endproperty
  a_reset: assert property (p_reset)
    else $error("loop reset wrong after control write");
  property p_power;
    ctl_wr |-> ##2 o_loop_power_down == $past(i_wdata[1], 2);
  endproperty
  a_power: assert property (p_power)
    else $error("power down wrong after control write");
  property p_refsel;
    ctl_wr |-> ##2 o_reference_select == $past(i_wdata[8], 2);
  endproperty
  a_refsel: assert property (p_refsel)
    else $error("reference select wrong after control write");
  // Mode bit counts only while the source gate is clear
  property p_bypass;
    ctl_wr |-> ##2
      o_bypass_off == ($past(i_wdata[0], 2) & ~$past(i_wdata[5], 2));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("effective mode wrong after control write");
  property p_factor;
    mul_wr |-> ##2
      o_loop_multiply_factor == {1'b0, $past(i_wdata[4:0], 2)} + 6'h01;
  endproperty
  a_factor: assert property (p_factor)
    else $error("multiply factor is not field plus one");
  property p_tick_one;
    o_system_clock_one && sel_age >= 3'h3 |->
      !$past(o_system_clock_one, 1) && !$past(o_system_clock_one, 2) &&
      !$past(o_system_clock_one, 3);
  endproperty
  a_tick_one: assert property (p_tick_one)
    else $error("system clock one tick too long or too close");
  property p_tick_two;
    o_system_clock_two && sel_age >= 3'h3 |->
      !$past(o_system_clock_two, 1) && !$past(o_system_clock_two, 2) &&
      !$past(o_system_clock_two, 3);
  endproperty
  a_tick_two: assert property (p_tick_two)
    else $error("system clock two tick too long or too close");
  c_ctl: cover property (ctl_wr ##2 o_bypass_off);
  c_mul: cover property (mul_wr);
  c_one: cover property (o_system_clock_one);
endmodule

// [pll_control_and_divider_regs_bench.sv]
// Purpose: Register and divider tests of both controller flavours.
// Assumes: Both instances share one register port.
// Notes:   Tick gaps in bus cycles; 400 means no tick seen.
`timescale 1ns/1ps
`include "pll_ctrl_regs.vh"
module pll_control_and_divider_regs_bench;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [`ADDR_W-1:0] i_addr = 10'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  wire osc, ext, lp;
  wire [31:0] rd_a, rd_b;
  wire [10:0] st;
  wire [3:0] tk;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] cw [3] = '{32'h0000_0109, 32'h0000_0100, 32'hFFFF_FE3F};
  logic [31:0] cr [3] = '{32'h0000_01C9, 32'h0000_01C0, 32'h0000_00FB};
  logic [4:0] cs [3] = '{5'h0b, 5'h02, 5'h1c};
  int cg [3] = '{40, 32, 24};

  clock_pin_source src (.i_mclk(i_mclk), .o_osc(osc), .o_ext(ext),
    .o_loop(lp));
  loop_clock_control #(.SECOND_CONTROLLER(0)) dut (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rd_a), .i_oscillator_input(osc),
    .i_external_square_clock(ext), .i_loop_clock(lp),
    .o_loop_disable(st[4]), .o_loop_reset_n(st[3]),
    .o_loop_power_down(st[2]), .o_loop_multiply_factor(st[10:5]),
    .o_reference_select(st[1]), .o_bypass_off(st[0]),
    .o_system_clock_one(tk[0]), .o_system_clock_two(tk[1]));
  loop_clock_control #(.SECOND_CONTROLLER(1)) dut_b (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rd_b), .i_oscillator_input(osc),
    .i_external_square_clock(ext), .i_loop_clock(lp),
    .o_loop_disable(), .o_loop_reset_n(), .o_loop_power_down(),
    .o_loop_multiply_factor(), .o_reference_select(), .o_bypass_off(),
    .o_system_clock_one(tk[2]), .o_system_clock_two(tk[3]));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [31:0] ea, input logic [31:0] eb);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(rd_a, ea);
    chk(rd_b, eb);
  endtask
  // Skips two ticks so a source or ratio change has settled
  task gap(input int sel, input int exp);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge i_mclk);
        #1;
        n++;
      end while (tk[sel] !== 1'b1 && n < 400);
    end
    chk(n, exp);
  endtask
  task results;
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    #100000;
    fail_count++;
    results;
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    chk(st, {6'h11, 5'h14});
    rd(`OFF_LOOP_CONTROL, 32'h0000_00F2, 32'h0000_00F2);
    rd(`OFF_LOOP_MULTIPLIER, 32'h0000_0010, 32'h0000_0010);
    rd(`OFF_DIVIDER_ONE, 32'h0000_0000, 32'h0000_0001);
    rd(`OFF_DIVIDER_TWO, 32'h0000_8001, 32'h0000_8009);
    rd(10'h104, 32'h0000_0000, 32'h0000_0000);
    gap(0, 400);
    gap(1, 12);
    gap(3, 60);
    wr(`OFF_DIVIDER_ONE, 32'hFFFF_8003);
    wr(`OFF_DIVIDER_TWO, 32'h0000_8002);
    wr(`OFF_GO_COMMAND, 32'h0000_0000);
    rd(`OFF_DIVIDER_STATUS, 32'h0000_0010, 32'h0000_0091);
    wr(`OFF_GO_COMMAND, 32'h0000_0001);
    rd(`OFF_DIVIDER_STATUS, 32'h0000_0010, 32'h0000_0023);
    rd(`OFF_DIVIDER_ONE, 32'h0000_8000, 32'h0000_8003);
    rd(`OFF_DIVIDER_TWO, 32'h0000_8001, 32'h0000_8002);
    gap(0, 6);
    gap(2, 24);
    gap(1, 12);
    gap(3, 18);
    for (int i = 0; i < 3; i++) begin
      wr(`OFF_LOOP_CONTROL, cw[i]);
      rd(`OFF_LOOP_CONTROL, cr[i], cr[i]);
      chk(st, {6'h11, cs[i]});
      rd(`OFF_DIVIDER_STATUS, {cs[i][0], 8'h10}, {cs[i][0], 8'h23});
      gap(2, cg[i]);
    end
    wr(`OFF_LOOP_MULTIPLIER, 32'hFFFF_FFFF);
    rd(`OFF_LOOP_MULTIPLIER, 32'h0000_001F, 32'h0000_001F);
    chk(st[10:5], 6'h20);
    wr(`OFF_LOOP_MULTIPLIER, 32'h0000_0000);
    rd(`OFF_LOOP_MULTIPLIER, 32'h0000_0000, 32'h0000_0000);
    chk(st[10:5], 6'h01);
    wr(`OFF_DIVIDER_ONE, 32'h0000_0003);
    gap(0, 400);
    gap(2, 400);
    gap(3, 18);
    results;
  end
endmodule

bind loop_clock_control pll_control_and_divider_regs_chk chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_loop_disable(o_loop_disable),
  .o_loop_reset_n(o_loop_reset_n), .o_loop_power_down(o_loop_power_down),
  .o_loop_multiply_factor(o_loop_multiply_factor),
  .o_reference_select(o_reference_select), .o_bypass_off(o_bypass_off),
  .o_system_clock_one(o_system_clock_one),
  .o_system_clock_two(o_system_clock_two));
